/* hw/iptc_top.sv */
// I2C port timing, watchdog recovery and link parity check
//
// Overview of operation
// (R1) Parity checker works only while its enable is set; enable resets to one.
// (R2) Enable 0 disables, 1 enables; mismatched link data raises an error pulse.
// (R3) SDA input held after SCL falls, for 50 ns steps of field 6:4.
// (R4) Glitches on SCL and SDA up to 5 ns steps of field 3:0 rejected.
// (R5) Remote ACK: SDA set 80 ns plus 640 ns per step before SCL rises.
// (R6) SDA output changes 240 ns plus 40 ns per step after SCL falls.
// (R7) Watchdog expires after one second, or 50 us with the fast bit.
// (R8) Watchdog stopped while its disable bit is set; runs by default.
// (R9) SDA high and idle for the interval marks the bus free.
// (R10) SDA low and idle for the interval starts nine recovery SCL pulses.
// (R11) Master SCL high time is 40 ns times high setting plus four.
// (R12) Master SCL low time is 40 ns times low setting plus four; remote setup.
// (R13) Default settings give about 100 kHz at a 25 MHz oscillator.
// (R14) Software allows for ten percent oscillator spread when programming widths.
// (R15) Only master SCL phase counts run at the oscillator rate, half the core clock; other timings count core cycles.
`timescale 1ns/1ps
`include "iptc_map.svh"
`default_nettype none
module iptc_top
   import iptc_pkg::*;
#(
   parameter int WD_SLOW_CYC = `IPTC_WD_SLOW_US * `IPTC_CLK_MHZ
) (
   input  wire logic              core_clk_in,
   input  wire logic              reset_n_in,
   input  wire logic [7:0]        addr_in,
   input  wire logic [7:0]        wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output var  logic [7:0]        rdata_out,
   input  wire logic              scl_in,
   output var  logic              scl_out,
   output var  logic              scl_oe_out,
   input  wire logic              sda_in,
   output var  logic              sda_out,
   output var  logic              sda_oe_out,
   input  wire logic              master_en_in,
   input  wire logic              remote_active_in,
   input  wire logic              remote_ack_in,
   input  wire logic              sda_tx_in,
   output var  logic              scl_rx_out,
   output var  logic              sda_rx_out,
   output var  logic              bus_free_out,
   output var  logic              local_wr_dis_out,
   input  wire iptc_pkg::iptc_link_t link_in,
   output var  logic              parity_err_out
);
   import iptc_pkg::*;

   localparam int OSC_DIV     = `IPTC_OSC_NS / `IPTC_CLK_NS;
   localparam int WD_FAST_CYC = `IPTC_WD_FAST_US * `IPTC_CLK_MHZ;

   // Least times round up to whole core cycles
   function automatic logic [15:0] ceil_cyc(input int ns);
      return 16'((ns + `IPTC_CLK_NS - 1) / `IPTC_CLK_NS);
   endfunction

   iptc_regs_t  regs_q;
   iptc_regs_t  regs_d;
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;
   logic        osc_tick_q;
   logic        scl_f;
   logic        sda_f;
   logic        scl_p_q;
   logic        sda_p_q;
   logic        scl_fall;
   logic        activity;
   logic [15:0] filt_cyc;
   logic [15:0] hold_cyc;
   logic [15:0] dly_cyc;
   logic [15:0] su_cyc;
   logic [15:0] hold_cnt_q;
   logic [15:0] hold_cnt_d;
   logic        sda_rx_q;
   logic        sda_rx_d;
   logic        scl_rx_q;
   logic [15:0] dly_cnt_q;
   logic [15:0] dly_cnt_d;
   logic        dly_run_q;
   logic        dly_run_d;
   logic        dly_done;
   logic        sda_q;
   logic        sda_d;
   iptc_state_t st_q;
   iptc_state_t st_d;
   logic [15:0] ph_q;
   logic [15:0] ph_d;
   logic [3:0]  rec_q;
   logic [3:0]  rec_d;
   logic [31:0] wd_q;
   logic [31:0] wd_d;
   logic        free_q;
   logic        free_d;
   logic        expire;
   logic        scl_oe_q;
   logic        par_err_q;
   logic        sda_oe_q;

   // Register file; low setting also paces remote setup outside ACK
   always_comb begin
      regs_d  = regs_q;
      rdata_d = 8'h00;
      if (wr_in) begin
         unique case (addr_in)
            `IPTC_ADDR_CTRL:       regs_d.ctrl       = wdata_in & 8'h02;
            `IPTC_ADDR_FILT_HOLD:  regs_d.filt_hold  = wdata_in;
            `IPTC_ADDR_ACK_TIMING: regs_d.ack_timing = wdata_in;
            `IPTC_ADDR_SCL_HIGH:   regs_d.scl_high   = wdata_in;
            `IPTC_ADDR_SCL_LOW:    regs_d.scl_low    = wdata_in;
            default:               regs_d            = regs_q;
         endcase
      end
      if (rd_in) begin
         unique case (addr_in)
            `IPTC_ADDR_CTRL:       rdata_d = regs_q.ctrl;
            `IPTC_ADDR_FILT_HOLD:  rdata_d = regs_q.filt_hold;
            `IPTC_ADDR_ACK_TIMING: rdata_d = regs_q.ack_timing;
            `IPTC_ADDR_SCL_HIGH:   rdata_d = regs_q.scl_high;
            `IPTC_ADDR_SCL_LOW:    rdata_d = regs_q.scl_low;
            `IPTC_ADDR_STATUS:     rdata_d = {4'h0, rec_q != 4'h0, scl_oe_q, sda_f, free_q};
            default:               rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         regs_q.ctrl       <= `IPTC_RST_CTRL; // [R1]
         regs_q.filt_hold  <= `IPTC_RST_FILT_HOLD;
         regs_q.ack_timing <= `IPTC_RST_ACK_TIMING;
         regs_q.scl_high   <= `IPTC_RST_SCL_HIGH; // [R13]
         regs_q.scl_low    <= `IPTC_RST_SCL_LOW;
         rdata_q           <= 8'h00;
      end else begin
         regs_q  <= regs_d;
         rdata_q <= rdata_d;
      end
   end

   // Field decode into core cycles
   always_comb begin
      filt_cyc = ceil_cyc(int'(regs_q.filt_hold[`IPTC_FILT_LSB +: 4]) * `IPTC_FILT_STEP_NS); // [R4]
      hold_cyc = ceil_cyc(int'(regs_q.filt_hold[`IPTC_HOLD_LSB +: 3]) * `IPTC_HOLD_STEP_NS); // [R3]
      dly_cyc  = ceil_cyc(`IPTC_DLY_BASE_NS + int'(regs_q.ack_timing[`IPTC_DLY_LSB +: 2]) * `IPTC_DLY_STEP_NS); // [R6]
      if (remote_ack_in) begin
         su_cyc = ceil_cyc(`IPTC_SU_BASE_NS + int'(regs_q.ack_timing[`IPTC_SU_LSB +: 4]) * `IPTC_SU_STEP_NS); // [R5]
      end else begin
         su_cyc = 16'((int'(regs_q.scl_low) + `IPTC_SCL_EXTRA) * OSC_DIV); // [R12]
      end
   end

   // Oscillator-rate enable; widths stay in oscillator periods as software expects
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         osc_tick_q <= 1'b0;
      end else begin
         osc_tick_q <= ~osc_tick_q; // [R15]
      end
   end

   iptc_glitch_filter #(.CW(16)) u_scl_filt (
      .core_clk_in (core_clk_in),
      .reset_n_in  (reset_n_in),
      .raw_in      (scl_in),
      .depth_in    (filt_cyc),
      .filt_out    (scl_f)
   );

   iptc_glitch_filter #(.CW(16)) u_sda_filt (
      .core_clk_in (core_clk_in),
      .reset_n_in  (reset_n_in),
      .raw_in      (sda_in),
      .depth_in    (filt_cyc),
      .filt_out    (sda_f)
   );

   assign scl_fall = scl_p_q & ~scl_f;
   assign activity = (scl_p_q ^ scl_f) | (sda_p_q ^ sda_f);
   assign dly_done = dly_run_q && (dly_cnt_q == dly_cyc - 16'h0001);

   // Input hold and output delay after each SCL fall
   always_comb begin
      hold_cnt_d = hold_cnt_q;
      sda_rx_d   = sda_rx_q;
      dly_cnt_d  = dly_cnt_q;
      dly_run_d  = dly_run_q;
      sda_d      = sda_q;
      if (scl_fall) begin
         hold_cnt_d = hold_cyc; // [R3]
      end else if (hold_cnt_q != 16'h0000) begin
         hold_cnt_d = hold_cnt_q - 16'h0001;
      end else begin
         sda_rx_d = sda_f;
      end
      if (scl_fall) begin
         dly_run_d = 1'b1;
         dly_cnt_d = 16'h0000;
      end else if (dly_done) begin
         dly_run_d = 1'b0; // [R6]
      end else if (dly_run_q) begin
         dly_cnt_d = dly_cnt_q + 16'h0001;
      end
      // Recovery must leave SDA released so the stuck target can let go
      if (rec_q != 4'h0) begin
         sda_d = 1'b1; // [R10]
      end else if (dly_done) begin
         sda_d = sda_tx_in; // [R6]
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         scl_p_q    <= 1'b1;
         sda_p_q    <= 1'b1;
         hold_cnt_q <= 16'h0000;
         sda_rx_q   <= 1'b1;
         scl_rx_q   <= 1'b1;
         dly_cnt_q  <= 16'h0000;
         dly_run_q  <= 1'b0;
         sda_q      <= 1'b1;
      end else begin
         scl_p_q    <= scl_f;
         sda_p_q    <= sda_f;
         hold_cnt_q <= hold_cnt_d;
         sda_rx_q   <= sda_rx_d;
         scl_rx_q   <= scl_f;
         dly_cnt_q  <= dly_cnt_d;
         dly_run_q  <= dly_run_d;
         sda_q      <= sda_d;
      end
   end

   assign expire = !regs_q.ctrl[`IPTC_WD_DIS_BIT] && regs_q.ack_timing[`IPTC_WD_DIS_BIT] == 1'b0 &&
                   !activity && (wd_q == 32'(regs_q.ack_timing[`IPTC_WD_FAST_BIT] ? WD_FAST_CYC - 1
                                                                                  : WD_SLOW_CYC - 1)); // [R7]

   // SCL driver, watchdog and bus recovery
   always_comb begin
      st_d   = st_q;
      ph_d   = ph_q;
      rec_d  = rec_q;
      wd_d   = wd_q;
      free_d = free_q;
      if (regs_q.ack_timing[`IPTC_WD_DIS_BIT] || activity) begin
         wd_d   = 32'h0000_0000; // [R8]
         free_d = activity ? 1'b0 : free_q;
      end else if (expire) begin
         wd_d = 32'h0000_0000;
         if (sda_f) begin
            free_d = 1'b1; // [R9]
         end else if (rec_q == 4'h0) begin
            rec_d = `IPTC_RECOVER_PULSES; // [R10]
         end
      end else begin
         wd_d = wd_q + 32'h0000_0001;
      end
      unique case (st_q)
         S_IDLE: begin
            ph_d = 16'h0000;
            if (rec_q != 4'h0 || master_en_in) begin
               st_d = S_CLK_LO;
            end else if (remote_active_in && scl_fall) begin
               st_d = S_SLV_DLY;
            end
         end
         S_SLV_DLY: begin
            if (dly_done) begin
               st_d = S_SLV_SU;
               ph_d = 16'h0000;
            end
         end
         S_SLV_SU: begin
            if (ph_q >= su_cyc - 16'h0001) begin
               st_d = S_IDLE; // [R5] [R12]
            end else begin
               ph_d = ph_q + 16'h0001;
            end
         end
         S_CLK_LO: begin
            if (osc_tick_q) begin
               if (ph_q >= 16'(regs_q.scl_low) + 16'(`IPTC_SCL_EXTRA) - 16'h0001) begin
                  st_d = S_CLK_HI; // [R12]
                  ph_d = 16'h0000;
               end else begin
                  ph_d = ph_q + 16'h0001;
               end
            end
         end
         S_CLK_HI: begin
            // High time counts only once SCL is seen high, so a stretching target is honoured
            if (osc_tick_q && scl_f) begin
               if (ph_q >= 16'(regs_q.scl_high) + 16'(`IPTC_SCL_EXTRA) - 16'h0001) begin
                  ph_d = 16'h0000; // [R11]
                  if (rec_q != 4'h0 && rec_d == rec_q) begin
                     rec_d = rec_q - 4'h1;
                  end
                  st_d = (master_en_in || rec_d != 4'h0) ? S_CLK_LO : S_IDLE;
               end else begin
                  ph_d = ph_q + 16'h0001;
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         st_q      <= S_IDLE;
         ph_q      <= 16'h0000;
         rec_q     <= 4'h0;
         wd_q      <= 32'h0000_0000;
         free_q    <= 1'b0;
         scl_oe_q  <= 1'b0;
         par_err_q <= 1'b0;
      end else begin
         st_q      <= st_d;
         ph_q      <= ph_d;
         rec_q     <= rec_d;
         wd_q      <= wd_d;
         free_q    <= free_d;
         scl_oe_q  <= (st_d == S_SLV_DLY) || (st_d == S_SLV_SU) || (st_d == S_CLK_LO);
         par_err_q <= link_in.valid && regs_q.ctrl[`IPTC_PAR_EN_BIT] && (^link_in.data != link_in.parity); // [R1] [R2]
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
         // Pull-down mirrors the SDA flop so the pin comes straight off a register
         sda_oe_q <= ~sda_d;
      end
   end

   assign rdata_out        = rdata_q;
   assign scl_oe_out       = scl_oe_q;
   assign sda_oe_out       = sda_oe_q;
   assign scl_rx_out       = scl_rx_q;
   assign sda_rx_out       = sda_rx_q;
   assign bus_free_out     = free_q;
   assign local_wr_dis_out = regs_q.filt_hold[`IPTC_LWD_BIT];
   assign parity_err_out   = par_err_q;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_hung;
      expire && !sda_f && rec_q == 4'h0;
   endsequence
   sequence s_idle_high;
      expire && sda_f;
   endsequence

   a_parity_gated: assert property (parity_err_out |-> $past(regs_q.ctrl[`IPTC_PAR_EN_BIT] && link_in.valid)) // [R1]
      else $error("parity error flagged while checker disabled");
   a_parity_detect: assert property ((link_in.valid && regs_q.ctrl[`IPTC_PAR_EN_BIT] // [R2]
      && (^link_in.data != link_in.parity)) |=> parity_err_out)
      else $error("parity mismatch not flagged");
   a_hold_freeze: assert property ((hold_cnt_q != 16'h0000) |=> $stable(sda_rx_q)) // [R3]
      else $error("sda input changed inside hold window");
   a_setup_length: assert property ((st_q == S_SLV_SU) && (st_d == S_IDLE) |-> ph_q >= su_cyc - 16'h0001) // [R5]
      else $error("remote setup ended early");
   a_delay_point: assert property ((sda_q != $past(sda_q)) |-> $past(dly_done || rec_q != 4'h0)) // [R6]
      else $error("sda output moved off the delay point");
   a_wd_fast: assert property (expire && regs_q.ack_timing[`IPTC_WD_FAST_BIT] |-> wd_q == 32'(WD_FAST_CYC - 1)) // [R7]
      else $error("fast watchdog expired at wrong count");
   a_wd_off: assert property (regs_q.ack_timing[`IPTC_WD_DIS_BIT] |=> wd_q == 32'h0000_0000) // [R8]
      else $error("watchdog ran while disabled");
   a_bus_free: assert property (s_idle_high |=> bus_free_out) // [R9]
      else $error("idle high bus not marked free");
   a_recover_start: assert property (s_hung |=> rec_q == `IPTC_RECOVER_PULSES ##1 st_q == S_CLK_LO) // [R10]
      else $error("hung bus did not start recovery pulses");
   a_high_time: assert property ((st_q == S_CLK_HI) && (st_d != S_CLK_HI) // [R11]
      |-> ph_q == 16'(regs_q.scl_high) + 16'(`IPTC_SCL_EXTRA) - 16'h0001)
      else $error("scl high phase length wrong");
endmodule
`default_nettype wire

/* hw/iptc_map.svh */
// Register offsets, field positions, reset values and timing figures of the I2C port timing block
`ifndef IPTC_MAP_SVH
`define IPTC_MAP_SVH
`define IPTC_ADDR_CTRL        8'h02
`define IPTC_ADDR_FILT_HOLD   8'h08
`define IPTC_ADDR_ACK_TIMING  8'h09
`define IPTC_ADDR_SCL_HIGH    8'h0a
`define IPTC_ADDR_SCL_LOW     8'h0b
`define IPTC_ADDR_STATUS      8'h10
`define IPTC_RST_CTRL         8'h02
`define IPTC_RST_FILT_HOLD    8'h1c
`define IPTC_RST_ACK_TIMING   8'h10
`define IPTC_RST_SCL_HIGH     8'h7a
`define IPTC_RST_SCL_LOW      8'h7a
`define IPTC_PAR_EN_BIT       1
`define IPTC_LWD_BIT          7
`define IPTC_HOLD_LSB         4
`define IPTC_FILT_LSB         0
`define IPTC_SU_LSB           4
`define IPTC_DLY_LSB          2
`define IPTC_WD_FAST_BIT      1
`define IPTC_WD_DIS_BIT       0
`define IPTC_CLK_NS           20
`define IPTC_OSC_NS           40
`define IPTC_CLK_MHZ          50
`define IPTC_FILT_STEP_NS     5
`define IPTC_HOLD_STEP_NS     50
`define IPTC_SU_BASE_NS       80
`define IPTC_SU_STEP_NS       640
`define IPTC_DLY_BASE_NS      240
`define IPTC_DLY_STEP_NS      40
`define IPTC_SCL_EXTRA        4
`define IPTC_RECOVER_PULSES   4'h9
`define IPTC_WD_SLOW_US       1000000
`define IPTC_WD_FAST_US       50
`endif

/* hw/iptc_pkg.sv */
// Types shared by the I2C port timing block
package iptc_pkg;
   typedef struct packed {
      logic        valid;
      logic        parity;
      logic [11:0] data;
   } iptc_link_t;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] filt_hold;
      logic [7:0] ack_timing;
      logic [7:0] scl_high;
      logic [7:0] scl_low;
   } iptc_regs_t;
   typedef enum logic [2:0] {
      S_IDLE    = 3'b000,
      S_SLV_DLY = 3'b001,
      S_SLV_SU  = 3'b010,
      S_CLK_LO  = 3'b011,
      S_CLK_HI  = 3'b100
   } iptc_state_t;
endpackage

/* hw/iptc_glitch_filter.sv */
// Glitch filter for one I2C input line
`timescale 1ns/1ps
`default_nettype none
module iptc_glitch_filter #(
   parameter int CW = 16
) (
   input  wire logic          core_clk_in,
   input  wire logic          reset_n_in,
   input  wire logic          raw_in,
   input  wire logic [CW-1:0] depth_in,
   output var  logic          filt_out
);
   logic          filt_q;
   logic          filt_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // A level is taken only after it has differed for depth+1 cycles
   always_comb begin
      filt_d = filt_q;
      cnt_d  = '0;
      if (raw_in != filt_q) begin
         if (cnt_q >= depth_in) begin
            filt_d = raw_in; // [R4]
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         filt_q <= 1'b1;
         cnt_q  <= '0;
      end else begin
         filt_q <= filt_d;
         cnt_q  <= cnt_d;
      end
   end

   assign filt_out = filt_q;

   a_filter_reject: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R4]
      (filt_q != $past(filt_q)) |-> ($past(cnt_q) >= $past(depth_in)))
      else $error("filtered line changed before the glitch width elapsed");
endmodule
`default_nettype wire

/* dv/iptc_bus_agent.sv */
// Local I2C bus party: clocks SCL as controller, stretches SCL as target, drives SDA
`timescale 1ns/1ps
`default_nettype none
module iptc_bus_agent (
   input  wire logic       core_clk_in,
   input  wire logic       scl_in,
   input  wire logic [7:0] stretch_in,
   output var  logic       scl_low_out,
   output var  logic       sda_low_out
);
   logic       ctl_low_q;
   logic       scl_q;
   logic [7:0] hold_q;
   initial begin
      ctl_low_q = 1'b0;
      sda_low_out = 1'b0;
      scl_q = 1'b1;
      hold_q = 8'h00;
   end
   // A slow target keeps SCL low after every fall it sees on the wire
   always @(posedge core_clk_in) begin
      scl_q <= scl_in;
      if (scl_q && !scl_in) begin
         hold_q <= stretch_in;
      end else if (hold_q != 8'h00) begin
         hold_q <= hold_q - 8'h01;
      end
   end
   // Released lines fall back to the pull-up level
   assign scl_low_out = ctl_low_q | (hold_q != 8'h00);
   task automatic set_scl(input logic v);
      @(posedge core_clk_in);
      ctl_low_q <= !v;
   endtask
   task automatic set_sda(input logic v);
      @(posedge core_clk_in);
      sda_low_out <= !v;
   endtask
   task automatic glitch_sda(input int w);
      set_sda(1'b0);
      repeat (w - 1) @(posedge core_clk_in);
      set_sda(1'b1);
   endtask
endmodule
`default_nettype wire

/* dv/iptc_top_tb.sv */
// Self-checking bench for the I2C port timing block
`timescale 1ns/1ps
`default_nettype none
module iptc_top_tb;
   import iptc_pkg::*;
   localparam int WD = 3000;
   logic       clk;
   logic       rst_n;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       scl_oe;
   logic       sda_oe;
   logic       master_en;
   logic       rem_act;
   logic       rem_ack;
   logic       sda_tx;
   logic       scl_rx;
   logic       sda_rx;
   logic       bus_free;
   logic       lwd;
   logic       perr;
   logic       scl_o;
   logic       sda_o;
   logic       a_scl_low;
   logic       a_sda_low;
   logic [7:0] stretch;
   iptc_link_t link;
   int         mismatches;
   int         checks_done;
   int         n;
   int         m;
   logic [7:0] ra [5] = '{8'h02, 8'h08, 8'h09, 8'h0a, 8'h0b};
   logic [7:0] rv [5] = '{8'h02, 8'h1c, 8'h10, 8'h7a, 8'h7a};
   wire        scl_w = !(scl_oe | a_scl_low);
   wire        sda_w = !(sda_oe | a_sda_low);
   iptc_top #(
      .WD_SLOW_CYC (WD)
   ) i_dut (
      .core_clk_in      (clk),
      .reset_n_in       (rst_n),
      .addr_in          (addr),
      .wdata_in         (wdata),
      .wr_in            (wr),
      .rd_in            (rd),
      .rdata_out        (rdata),
      .scl_in           (scl_w),
      .scl_out          (scl_o),
      .scl_oe_out       (scl_oe),
      .sda_in           (sda_w),
      .sda_out          (sda_o),
      .sda_oe_out       (sda_oe),
      .master_en_in     (master_en),
      .remote_active_in (rem_act),
      .remote_ack_in    (rem_ack),
      .sda_tx_in        (sda_tx),
      .scl_rx_out       (scl_rx),
      .sda_rx_out       (sda_rx),
      .bus_free_out     (bus_free),
      .local_wr_dis_out (lwd),
      .link_in          (link),
      .parity_err_out   (perr)
   );
   iptc_bus_agent i_agent (
      .core_clk_in (clk),
      .scl_in      (scl_w),
      .stretch_in  (stretch),
      .scl_low_out (a_scl_low),
      .sda_low_out (a_sda_low)
   );
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi, input string what);
      checks_done++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("ERROR %0t %s: %0d not in %0d..%0d", $time, what, got, lo, hi);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp, "read");
   endtask
   task automatic send_link(input logic [11:0] d, input logic p, input logic exp);
      @(posedge clk);
      link <= '{valid: 1'b1, parity: p, data: d};
      @(posedge clk);
      link.valid <= 1'b0;
      #1;
      chk(perr, exp, "parity flag");
   endtask
   // Counts cycles until s equals v; a bound that runs out is fatal only when must is set
   task automatic wait_for(ref logic s, input logic v, input int lim, input bit must, output int cnt);
      cnt = 0;
      while (s !== v && cnt < lim) begin
         @(posedge clk);
         #1;
         cnt++;
      end
      if (must && s !== v) begin
         mismatches++;
         $display("ERROR %0t wait ran out", $time);
         final_report();
      end
   endtask
   // Skips any pulse already under way so only a whole one is measured
   task automatic pulse_len(ref logic s, input logic v, output int cnt);
      wait_for(s, !v, 8000, 1'b1, cnt);
      wait_for(s, v, 8000, 1'b1, cnt);
      wait_for(s, !v, 8000, 1'b1, cnt);
   endtask
   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      master_en = 1'b0;
      rem_act = 1'b0;
      rem_ack = 1'b0;
      sda_tx = 1'b1;
      link = '0;
      stretch = 8'h00;
      mismatches = 0;
      checks_done = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         reg_rd(ra[i], rv[i]);
      end
      reg_rd(8'h3f, 8'h00);
      reg_wr(8'h02, 8'hfd);
      reg_rd(8'h02, 8'h00);
      send_link(12'h001, 1'b0, 1'b0);
      reg_wr(8'h02, 8'h02);
      send_link(12'h001, 1'b0, 1'b1);
      send_link(12'h003, 1'b0, 1'b0);
      send_link(12'h801, 1'b1, 1'b1);
      $display("test registers and parity done");
      fork
         i_agent.glitch_sda(2);
         wait_for(sda_rx, 1'b0, 12, 1'b0, n);
      join
      chk_rng(n, 12, 12, "short glitch");
      fork
         i_agent.glitch_sda(6);
         wait_for(sda_rx, 1'b0, 12, 1'b0, n);
      join
      chk_rng(n, 1, 11, "wide pulse");
      reg_wr(8'h08, 8'hbc);
      #1;
      chk(lwd, 1'b1, "write lock");
      fork
         begin
            i_agent.set_scl(1'b0);
            i_agent.set_sda(1'b0);
         end
         begin
            wait_for(scl_rx, 1'b0, 20, 1'b1, n);
            wait_for(sda_rx, 1'b0, 20, 1'b1, m);
         end
      join
      chk_rng(m, 6, 10, "sda hold");
      i_agent.set_sda(1'b1);
      i_agent.set_scl(1'b1);
      $display("test filter and hold done");
      master_en <= 1'b1;
      pulse_len(scl_oe, 1'b1, n);
      wait_for(scl_oe, 1'b1, 2000, 1'b1, m);
      chk_rng(n + m, 500, 515, "default period");
      reg_wr(8'h08, 8'h10);
      reg_wr(8'h0b, 8'h08);
      reg_wr(8'h0a, 8'h10);
      pulse_len(scl_oe, 1'b1, n);
      wait_for(scl_oe, 1'b1, 2000, 1'b1, m);
      chk_rng(n, 23, 26, "low time");
      chk_rng(m, 40, 46, "high time");
      stretch <= 8'd40;
      pulse_len(scl_oe, 1'b1, n);
      wait_for(scl_oe, 1'b1, 2000, 1'b1, m);
      chk_rng(m, 55, 63, "high after stretch");
      master_en <= 1'b0;
      stretch <= 8'h00;
      $display("test master clock done");
      i_agent.glitch_sda(6);
      wait_for(bus_free, 1'b1, 4000, 1'b1, n);
      chk_rng(n, WD - 50, WD + 50, "slow free");
      reg_rd(8'h10, 8'h03);
      i_agent.glitch_sda(6);
      wait_for(bus_free, 1'b0, 20, 1'b1, n);
      chk_rng(n, 0, 19, "free cleared");
      reg_wr(8'h09, 8'h12);
      i_agent.glitch_sda(6);
      wait_for(bus_free, 1'b1, 4000, 1'b1, n);
      chk_rng(n, 2450, 2550, "fast free");
      reg_wr(8'h0a, 8'h00);
      reg_wr(8'h0b, 8'h00);
      i_agent.set_sda(1'b0);
      wait_for(scl_oe, 1'b1, 4000, 1'b1, n);
      chk_rng(n, 2450, 2560, "recovery start");
      chk({6'h00, scl_o, sda_o}, 8'h00, "open drain level");
      // Window stays shorter than the fast watchdog so a second recovery cannot add pulses
      m = 1;
      n = 1;
      for (int i = 0; i < 400; i++) begin
         @(posedge clk);
         #1;
         m += (scl_oe && n == 0) ? 1 : 0;
         n = int'(scl_oe);
      end
      chk_rng(m, 9, 9, "recovery pulses");
      reg_wr(8'h09, 8'h13);
      wait_for(scl_oe, 1'b1, 3000, 1'b0, n);
      chk_rng(n, 3000, 3000, "disabled watchdog");
      i_agent.set_sda(1'b1);
      $display("test watchdog done");
      for (int c = 0; c < 4; c++) begin
         reg_wr(8'h09, {4'h0, c[1:0], 2'b01});
         sda_tx <= c[0];
         i_agent.set_scl(1'b0);
         wait_for(sda_oe, !c[0], 40, 1'b1, n);
         chk_rng(n, 12 + 2 * c, 16 + 2 * c, "sda delay");
         i_agent.set_scl(1'b1);
         repeat (10) @(posedge clk);
      end
      rem_act <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         rem_ack <= (k == 0);
         reg_wr(8'h09, (k == 0) ? 8'h11 : 8'h01);
         fork
            begin
               i_agent.set_scl(1'b0);
               repeat (3) @(posedge clk);
               i_agent.set_scl(1'b1);
            end
            pulse_len(scl_oe, 1'b1, n);
         join
         m = (k == 0) ? 48 : 20;
         chk_rng(n, m - 3, m + 2, "remote setup");
      end
      $display("test slave timing done");
      final_report();
   end
endmodule
`default_nettype wire
